// file: common/lisd_defs.vh
// Shared constants for the local input stream delay block.
`ifndef LISD_DEFS_VH
`define LISD_DEFS_VH

// Register map, word addresses on the microprocessor port.
`define LISD_ADDR_W 7
`define LISD_DATA_W 16
`define LISD_CD_BASE 7'h03
`define LISD_BD_BASE 7'h23
`define LISD_MAP_END 7'h42
`define LISD_IDX_W 6
`define LISD_STREAM_W 5

// Field widths and reset values.
`define LISD_CD_W 8
`define LISD_BD_W 5
`define LISD_CD_RESET 8'h00
`define LISD_BD_RESET 5'h00
`define LISD_RSV_CD 8'h00
`define LISD_RSV_BD 3'h0

// Stream rate codes: 2, 4, 8 and 16 Mb/s.
`define LISD_RATE_2M 2'h0
`define LISD_RATE_4M 2'h1
`define LISD_RATE_8M 2'h2
`define LISD_RATE_16M 2'h3

// Frame timing in quarter-bit ticks of a 16 Mb/s stream.
`define LISD_FQ_W 13
`define LISD_FQ_ONES 13'h1FFF
`define LISD_FQ_ZERO 13'h0000
`define LISD_Q_PER_CH_LOG 5
`define LISD_SAMPLE_PHASE 2'h0
`define LISD_LAST_BIT 3'h7
`define LISD_BYTE_W 8

`endif

// file: design/delay_reg_mem.v
// Register-file memory holding the programmed delay values.
`timescale 1ns/1ps
module delay_reg_mem #(
  parameter DW = 8,
  parameter AW = 6,
  parameter DEPTH = 64
) (
  input wire i_clk_sys,
  input wire i_reset,
  input wire i_we,
  input wire [AW-1:0] i_waddr,
  input wire [DW-1:0] i_wdata,
  input wire [AW-1:0] i_raddr,
  output reg [DW-1:0] o_rdata
);
  reg [DW-1:0] mem_r [0:DEPTH-1];
  integer k;

  // ==========================================================
  // Storage with registered read data.
  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      for (k = 0; k < DEPTH; k = k + 1) begin
        mem_r[k] <= {DW{1'b0}};
      end
      o_rdata <= {DW{1'b0}};
    end else begin
      if (i_we) begin
        mem_r[i_waddr] <= i_wdata;
      end
      o_rdata <= mem_r[i_raddr];
    end
  end
endmodule

// file: design/word_skid_buffer.v
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/1ps
module word_skid_buffer #(
  parameter WIDTH = 21
) (
  input wire i_clk_sys,
  input wire i_reset,
  input wire i_in_valid,
  output reg o_in_ready,
  input wire [WIDTH-1:0] i_in_data,
  output reg o_out_valid,
  input wire i_out_ready,
  output reg [WIDTH-1:0] o_out_data
);
  reg [WIDTH-1:0] tail_r;
  reg tail_v_r;
  wire push;
  wire pop;

  assign push = i_in_valid & o_in_ready;
  assign pop = o_out_valid & i_out_ready;

  // ==========================================================
  // Head feeds the output; tail catches a word during a stall.
  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_out_valid <= 1'b0;
      o_out_data <= {WIDTH{1'b0}};
      tail_r <= {WIDTH{1'b0}};
      tail_v_r <= 1'b0;
      o_in_ready <= 1'b0;
    end else begin
      if (pop) begin
        if (tail_v_r) begin
          o_out_data <= tail_r;
          tail_v_r <= push;
          if (push) begin
            tail_r <= i_in_data;
          end
          o_in_ready <= ~push;
        end else begin
          o_out_valid <= push;
          if (push) begin
            o_out_data <= i_in_data;
          end
          o_in_ready <= 1'b1;
        end
      end else if (push) begin
        if (!o_out_valid) begin
          o_out_valid <= 1'b1;
          o_out_data <= i_in_data;
          o_in_ready <= 1'b1;
        end else begin
          tail_v_r <= 1'b1;
          tail_r <= i_in_data;
          o_in_ready <= 1'b0;
        end
      end else begin
        o_in_ready <= ~tail_v_r;
      end
    end
  end
endmodule

// file: design/local_input_stream_delay.v
// Per-stream channel and quarter-bit input alignment for the local port.
`timescale 1ns/1ps
`include "lisd_defs.vh"
module local_input_stream_delay #(
  parameter STREAMS = 32
) (
  input wire i_clk_sys,
  input wire i_reset,
  input wire i_reg_cs,
  input wire i_reg_wr,
  input wire [`LISD_ADDR_W-1:0] i_reg_addr,
  input wire [`LISD_DATA_W-1:0] i_reg_wdata,
  output reg [`LISD_DATA_W-1:0] o_reg_rdata,
  output reg o_reg_ack,
  input wire i_frame_pulse,
  input wire i_quarter_tick,
  input wire [2*STREAMS-1:0] i_stream_rate,
  input wire [STREAMS-1:0] i_local_serial_inputs,
  output wire o_wr_valid,
  output wire [`LISD_STREAM_W-1:0] o_wr_stream,
  output wire [`LISD_CD_W-1:0] o_wr_channel,
  output wire [`LISD_BYTE_W-1:0] o_wr_data,
  input wire i_wr_ready
);
  localparam BUF_W = `LISD_STREAM_W + `LISD_CD_W + `LISD_BYTE_W;

  // ==========================================================
  // Register port decode.
  wire [`LISD_ADDR_W-1:0] reg_off;
  wire in_cd;
  wire in_bd;
  wire mapped;
  wire bus_wr;
  wire bus_rd;
  wire [`LISD_IDX_W-1:0] bus_idx;
  wire [`LISD_CD_W-1:0] wr_field;

  assign reg_off = i_reg_addr - `LISD_CD_BASE;
  assign in_cd = (i_reg_addr >= `LISD_CD_BASE) && (i_reg_addr < `LISD_BD_BASE);
  assign in_bd = (i_reg_addr >= `LISD_BD_BASE) && (i_reg_addr <= `LISD_MAP_END);
  assign mapped = in_cd | in_bd;
  assign bus_wr = i_reg_cs & i_reg_wr & mapped;
  assign bus_rd = i_reg_cs & ~i_reg_wr & mapped;
  assign bus_idx = reg_off[`LISD_IDX_W-1:0];

  assign wr_field = in_cd ? i_reg_wdata[`LISD_CD_W-1:0] :
                    {`LISD_RSV_BD, i_reg_wdata[`LISD_BD_W-1:0]};

  // ==========================================================
  // Programmed values and background sweep.
  reg [`LISD_IDX_W-1:0] sweep_idx_r;
  reg [`LISD_IDX_W-1:0] cap_idx_r;
  reg cap_r;
  reg s1_ack_r;
  reg s1_rd_r;
  wire [`LISD_IDX_W-1:0] mem_raddr;
  wire [`LISD_CD_W-1:0] mem_q;

  // A bus read takes the read port; the sweep then waits one cycle.
  assign mem_raddr = bus_rd ? bus_idx : sweep_idx_r;

  delay_reg_mem #(
    .DW(`LISD_CD_W),
    .AW(`LISD_IDX_W),
    .DEPTH(2 * STREAMS)
  ) u_mem (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .i_we(bus_wr),
    .i_waddr(bus_idx),
    .i_wdata(wr_field),
    .i_raddr(mem_raddr),
    .o_rdata(mem_q)
  );

  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      sweep_idx_r <= {`LISD_IDX_W{1'b0}};
      cap_idx_r <= {`LISD_IDX_W{1'b0}};
      cap_r <= 1'b0;
      s1_ack_r <= 1'b0;
      s1_rd_r <= 1'b0;
      o_reg_ack <= 1'b0;
      o_reg_rdata <= {`LISD_DATA_W{1'b0}};
    end else begin
      if (!bus_rd) begin
        sweep_idx_r <= sweep_idx_r + 1'b1;
      end
      cap_r <= ~bus_rd;
      cap_idx_r <= sweep_idx_r;
      s1_ack_r <= i_reg_cs;
      s1_rd_r <= bus_rd;
      o_reg_ack <= s1_ack_r;
      o_reg_rdata <= s1_rd_r ? {`LISD_RSV_CD, mem_q} : {`LISD_DATA_W{1'b0}};
    end
  end

  // ==========================================================
  // Frame position in quarter ticks of the fastest rate.
  reg [`LISD_FQ_W-1:0] fq_r;

  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      fq_r <= `LISD_FQ_ZERO;
    end else if (i_frame_pulse) begin
      fq_r <= `LISD_FQ_ZERO;
    end else if (i_quarter_tick) begin
      fq_r <= fq_r + 1'b1;
    end
  end

  // ==========================================================
  // Per-stream alignment and byte assembly.
  wire [STREAMS-1:0] pend;
  wire [STREAMS*`LISD_BYTE_W-1:0] hold_data;
  wire [STREAMS*`LISD_CD_W-1:0] hold_ch;
  wire buf_in_ready;
  reg [`LISD_STREAM_W-1:0] grant_idx;
  wire push;

  genvar i;
  generate
    for (i = 0; i < STREAMS; i = i + 1) begin : g_stream
      reg sync1_r;
      reg sync2_r;
      reg [`LISD_CD_W-1:0] cd_next_r;
      reg [`LISD_BD_W-1:0] bd_next_r;
      reg [`LISD_CD_W-1:0] cd_act_r;
      reg [`LISD_BD_W-1:0] bd_act_r;
      reg [`LISD_BYTE_W-1:0] sh_r;
      reg [`LISD_BYTE_W-1:0] data_r;
      reg [`LISD_CD_W-1:0] ch_r;
      reg pend_r;
      wire [1:0] rate;
      wire [1:0] shamt;
      wire [`LISD_FQ_W-1:0] sq;
      wire [`LISD_FQ_W-1:0] low_mask;
      wire [`LISD_FQ_W-1:0] frame_mask;
      wire [`LISD_FQ_W-1:0] pos;
      wire step;
      wire sample;
      wire last;
      wire clr;

      assign rate = i_stream_rate[2*i+1:2*i];
      assign shamt = `LISD_RATE_16M - rate;
      assign sq = fq_r >> shamt;
      assign low_mask = ~(`LISD_FQ_ONES << shamt);
      assign frame_mask = `LISD_FQ_ONES >> shamt;
      assign step = i_quarter_tick && ((fq_r & low_mask) == `LISD_FQ_ZERO);

      // Stream position after removing both delays, modulo its own frame.
      // Channel offset subtracted.
      assign pos = (sq - {{(`LISD_FQ_W-`LISD_BD_W){1'b0}}, bd_act_r}
                   - {cd_act_r, {`LISD_Q_PER_CH_LOG{1'b0}}}) & frame_mask;

      assign sample = step && (pos[1:0] == `LISD_SAMPLE_PHASE);
      assign last = pos[4:2] == `LISD_LAST_BIT;
      assign clr = push && (grant_idx == i);
      assign pend[i] = pend_r;
      assign hold_data[`LISD_BYTE_W*i +: `LISD_BYTE_W] = data_r;
      assign hold_ch[`LISD_CD_W*i +: `LISD_CD_W] = ch_r;

      always @(posedge i_clk_sys) begin
        if (i_reset) begin
          sync1_r <= 1'b0;
          sync2_r <= 1'b0;
          cd_next_r <= `LISD_CD_RESET;
          bd_next_r <= `LISD_BD_RESET;
          cd_act_r <= `LISD_CD_RESET;
          bd_act_r <= `LISD_BD_RESET;
          sh_r <= {`LISD_BYTE_W{1'b0}};
          data_r <= {`LISD_BYTE_W{1'b0}};
          ch_r <= {`LISD_CD_W{1'b0}};
          pend_r <= 1'b0;
        end else begin
          sync1_r <= i_local_serial_inputs[i];
          sync2_r <= sync1_r;
          if (cap_r && (cap_idx_r == i)) begin
            cd_next_r <= mem_q;
          end
          if (cap_r && (cap_idx_r == STREAMS + i)) begin
            bd_next_r <= mem_q[`LISD_BD_W-1:0];
          end
          if (i_frame_pulse) begin
            cd_act_r <= cd_next_r;
            bd_act_r <= bd_next_r;
          end
          if (sample) begin
            sh_r <= {sh_r[`LISD_BYTE_W-2:0], sync2_r};
          end
          if (sample && last) begin
            data_r <= {sh_r[`LISD_BYTE_W-2:0], sync2_r};
            ch_r <= pos[`LISD_CD_W+`LISD_Q_PER_CH_LOG-1:`LISD_Q_PER_CH_LOG];
          end
          // A new byte wins over a grant in the same cycle.
          pend_r <= (sample && last) | (pend_r & ~clr);
        end
      end
    end
  endgenerate

  // ==========================================================
  // Lowest-numbered pending stream goes to the buffer first.
  integer k;
  always @* begin
    grant_idx = {`LISD_STREAM_W{1'b0}};
    for (k = STREAMS - 1; k >= 0; k = k - 1) begin
      if (pend[k]) begin
        grant_idx = k[`LISD_STREAM_W-1:0];
      end
    end
  end

  assign push = (|pend) & buf_in_ready;

  wire [BUF_W-1:0] buf_in;
  wire [BUF_W-1:0] buf_out;

  assign buf_in = {grant_idx,
                   hold_ch[`LISD_CD_W*grant_idx +: `LISD_CD_W],
                   hold_data[`LISD_BYTE_W*grant_idx +: `LISD_BYTE_W]};

  word_skid_buffer #(
    .WIDTH(BUF_W)
  ) u_buf (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .i_in_valid(|pend),
    .o_in_ready(buf_in_ready),
    .i_in_data(buf_in),
    .o_out_valid(o_wr_valid),
    .i_out_ready(i_wr_ready),
    .o_out_data(buf_out)
  );

  assign o_wr_stream = buf_out[BUF_W-1:`LISD_CD_W+`LISD_BYTE_W];
  assign o_wr_channel = buf_out[`LISD_CD_W+`LISD_BYTE_W-1:`LISD_BYTE_W];
  assign o_wr_data = buf_out[`LISD_BYTE_W-1:0];
endmodule

// file: verif/lisd_checker.sv
// Port assertions for the local input stream delay block.
`timescale 1ns/1ps
`include "lisd_defs.vh"
module lisd_checker #(
  parameter STREAMS = 32
) (
  input wire i_clk_sys,
  input wire i_reset,
  input wire i_reg_cs,
  input wire i_reg_wr,
  input wire [`LISD_ADDR_W-1:0] i_reg_addr,
  input wire [`LISD_DATA_W-1:0] o_reg_rdata,
  input wire o_reg_ack,
  input wire [2*STREAMS-1:0] i_stream_rate,
  input wire o_wr_valid,
  input wire [`LISD_STREAM_W-1:0] o_wr_stream,
  input wire [`LISD_CD_W-1:0] o_wr_channel,
  input wire [`LISD_BYTE_W-1:0] o_wr_data,
  input wire i_wr_ready
);
  // ==========
  // Checks
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  wire [1:0] rt = i_stream_rate[2*o_wr_stream +: 2];
  sequence s_rd;
    i_reg_cs && !i_reg_wr;
  endsequence
  sequence s_stall;
    o_wr_valid && !i_wr_ready;
  endsequence
  chk_ack_delay: assert property (i_reg_cs |-> ##2 o_reg_ack)
    else $error("ack missing");
  chk_ack_cause: assert property (o_reg_ack |-> $past(i_reg_cs, 2))
    else $error("ack without request");
  chk_idle_rdata: assert property (!o_reg_ack |-> o_reg_rdata == 16'h0000)
    else $error("rdata outside ack");
  chk_cd_reserved: assert property (o_reg_ack |-> o_reg_rdata[15:8] == 8'h00)
    else $error("channel reserved bits set");
  chk_bd_reserved: assert property ((s_rd ##0 i_reg_addr >= 7'h23)
    |-> ##2 o_reg_rdata[15:5] == 11'h000)
    else $error("bit delay reserved bits set");
  chk_unmapped_zero: assert property ((s_rd ##0 (i_reg_addr < 7'h03 || i_reg_addr > 7'h42))
    |-> ##2 (o_reg_ack && o_reg_rdata == 16'h0000))
    else $error("unmapped read not zero");
  chk_stall_hold: assert property (s_stall |=> o_wr_valid &&
    $stable({o_wr_stream, o_wr_channel, o_wr_data}))
    else $error("word changed while stalled");
  chk_channel_range: assert property (o_wr_valid |-> {1'b0, o_wr_channel} < (9'h020 << rt))
    else $error("channel beyond rate frame");
  chk_reset_quiet: assert property ($past(i_reset) |-> !o_wr_valid && !o_reg_ack)
    else $error("output active after reset");
endmodule

// file: verif/stream_source_model.sv
// Serial sources for the local streams, each late by its own quarter-bit offset.
`timescale 1ns/1ps
module stream_source_model #(
  parameter STREAMS = 32
) (
  input wire i_clk_sys,
  input wire i_frame_pulse,
  input wire i_quarter_tick,
  input wire [2*STREAMS-1:0] i_stream_rate,
  output reg [STREAMS-1:0] o_lines
);
  reg [12:0] fq_r = 13'h0000;
  reg [12:0] sp;
  reg [1:0] rt;
  reg [7:0] d;
  integer off [STREAMS];
  integer n;
  integer j;
  // Offsets start at zero so the lines never carry unknown bits.
  initial begin
    for (j = 0; j < STREAMS; j = j + 1) begin
      off[j] = 0;
    end
  end
  always @(posedge i_clk_sys) begin
    if (i_frame_pulse) fq_r <= 13'h0000;
    else if (i_quarter_tick) fq_r <= fq_r + 13'h0001;
  end
  // Bits change half a bit before the receiver samples, so sampling lands mid-bit.
  always @* begin
    for (n = 0; n < STREAMS; n = n + 1) begin
      rt = i_stream_rate[2*n +: 2];
      sp = ((fq_r >> (3 - rt)) - off[n] + 2) & ((14'h0400 << rt) - 1);
      d = sp[12:5] ^ n[7:0];
      o_lines[n] = d[~sp[4:2]];
    end
  end
endmodule

// file: verif/local_input_stream_delay_tb.sv
// Bench for the local input stream delay block.
`timescale 1ns/1ps
module local_input_stream_delay_tb;
  reg i_clk_sys = 1'b0;
  reg i_reset = 1'b1;
  reg cs = 1'b0;
  reg wr = 1'b0;
  reg fp = 1'b0;
  reg tick = 1'b0;
  reg rdy = 1'b1;
  reg chk_on = 1'b0;
  reg [6:0] addr = 7'h00;
  reg [15:0] wd = 16'h0000;
  reg [63:0] rate = {8{8'hE4}};
  reg [15:0] cyc = 16'h0000;
  reg [31:0] rd;
  reg [31:0] seen = 32'h00000000;
  reg [7:0] cd [32];
  reg [7:0] last [32];
  reg [7:0] e;
  wire [31:0] lines;
  wire [15:0] rdata;
  wire ack, vld;
  wire [4:0] ws;
  wire [7:0] wch, wdat;
  integer miscompares = 0, comparisons = 0, i, k;
  always #50 i_clk_sys = ~i_clk_sys;
  local_input_stream_delay u_dut (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_reg_cs(cs),
    .i_reg_wr(wr), .i_reg_addr(addr), .i_reg_wdata(wd), .o_reg_rdata(rdata), .o_reg_ack(ack),
    .i_frame_pulse(fp), .i_quarter_tick(tick), .i_stream_rate(rate),
    .i_local_serial_inputs(lines), .o_wr_valid(vld), .o_wr_stream(ws), .o_wr_channel(wch),
    .o_wr_data(wdat), .i_wr_ready(rdy));
  stream_source_model u_src (.i_clk_sys(i_clk_sys), .i_frame_pulse(fp), .i_quarter_tick(tick),
    .i_stream_rate(rate), .o_lines(lines));
  // ==========
  // Tasks
  task check(input [31:0] got, input [31:0] exp);
    comparisons = comparisons + 1;
    if (got !== exp) begin
      miscompares = miscompares + 1;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task report_and_stop;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task acc(input w, input [6:0] a, input [15:0] d);
    integer t;
    @(posedge i_clk_sys) #1;
    cs = 1'b1;
    wr = w;
    addr = a;
    wd = d;
    @(posedge i_clk_sys) #1;
    cs = 1'b0;
    t = 0;
    while (ack !== 1'b1 && t < 4) begin
      @(posedge i_clk_sys) #1;
      t = t + 1;
    end
    if (t == 4) begin
      miscompares = miscompares + 1;
      report_and_stop;
    end else begin
      rd = {16'h0000, rdata};
    end
  endtask
  // ==========
  // Timing, stalls and received words
  always @(posedge i_clk_sys) begin
    cyc <= cyc + 16'h0001;
    tick <= #1 (cyc[1:0] == 2'b11);
    rdy <= #1 (cyc[5:4] != 2'b11);
  end
  always @(posedge i_clk_sys) begin
    if (chk_on && vld && rdy) begin
      e = last[ws] + 8'h01 & ((9'h020 << rate[2*ws +: 2]) - 9'h001);
      check({24'h0, wdat}, {24'h0, wch ^ {3'h0, ws}});
      if (seen[ws]) check({24'h0, wch}, {24'h0, e});
      seen[ws] = 1'b1;
      last[ws] = wch;
    end
  end
  // ==========
  // Sequence
  initial begin
    repeat (2) @(posedge i_clk_sys);
    #1 i_reset = 1'b0;
    for (i = 3; i < 67; i = i + 1) begin
      acc(1'b0, i[6:0], 16'h0000);
      check(rd, 32'h0);
    end
    for (i = 0; i < 4; i = i + 1) begin
      k = (i < 2) ? i * 2 : 67 + (i - 2) * 60;
      acc(1'b1, k[6:0], 16'hFFFF);
      acc(1'b0, k[6:0], 16'h0000);
      check(rd, 32'h0);
    end
    for (i = 0; i < 32; i = i + 1) begin
      k = (32 << rate[2*i +: 2]) - 1;
      cd[i] = (i < 4) ? k[7:0] : k[7:0] & (i * 37);
      acc(1'b1, 7'h03 + i[6:0], {8'hA5, cd[i]});
      acc(1'b1, 7'h23 + i[6:0], {11'h7FF, i[4:0]});
      u_src.off[i] = i + cd[i] * 32;
    end
    for (i = 0; i < 32; i = i + 1) begin
      acc(1'b0, 7'h03 + i[6:0], 16'h0000);
      check(rd, {24'h0, cd[i]});
      acc(1'b0, 7'h23 + i[6:0], 16'h0000);
      check(rd, {27'h0, i[4:0]});
    end
    @(posedge i_clk_sys) #1 fp = 1'b1;
    @(posedge i_clk_sys) #1 fp = 1'b0;
    repeat (1200) @(posedge i_clk_sys);
    #1 chk_on = 1'b1;
    repeat (15000) @(posedge i_clk_sys);
    // A mid-frame write must not disturb stream 4 before the next frame pulse.
    acc(1'b1, 7'h07, {8'h00, cd[4] ^ 8'h01});
    repeat (15995) @(posedge i_clk_sys);
    #1 chk_on = 1'b0;
    check(seen, 32'hFFFFFFFF);
    report_and_stop;
  end
endmodule
bind local_input_stream_delay lisd_checker #(.STREAMS(STREAMS)) u_chk (.i_clk_sys(i_clk_sys),
  .i_reset(i_reset), .i_reg_cs(i_reg_cs), .i_reg_wr(i_reg_wr), .i_reg_addr(i_reg_addr),
  .o_reg_rdata(o_reg_rdata), .o_reg_ack(o_reg_ack), .i_stream_rate(i_stream_rate),
  .o_wr_valid(o_wr_valid), .o_wr_stream(o_wr_stream), .o_wr_channel(o_wr_channel),
  .o_wr_data(o_wr_data), .i_wr_ready(i_wr_ready));
